// file: program_security_fuse_control_tb.sv
// Self-checking testbench for the program security and fuse burn block
`default_nettype none
module program_security_fuse_control_tb;
    timeunit 1ns;
    timeprecision 1ps;

    // ****************************************
    // Signals
    // ****************************************
    logic        clk;
    logic        rst_n;
    logic        sfr_write;
    logic        sfr_read;
    logic [7:0]  sfr_addr;
    logic        xdata_write;
    logic        xdata_read;
    logic [15:0] xdata_addr;
    logic [7:0]  wdata;
    logic [7:0]  rdata;
    logic        interrupts_enabled;
    logic        flash_byte_written;
    logic        erase_started;
    logic        select_pin;
    logic        level_zero_fuse;
    logic        level_one_fuse;
    logic        debug_read_req;
    logic [7:0]  flash_page;
    logic        pwe, mee, cpb, ppe, burn0, burn1, xblk, bulk, pz, dpd, grant;
    logic        rd_seen;
    logic [7:0]  exp_q[$];
    string       name_q[$];
    int          fail_count;
    int          n_tests;
    integer      seed;
    logic [7:0]  v;
    logic [7:0]  codes[2];
    // Software burn wait: about 500 us at 25 ns per cycle
    localparam int BURN_WAIT = 20000;

    security_fuse_control dut (
        .clk(clk), .rst_n(rst_n), .sfr_write(sfr_write), .sfr_read(sfr_read),
        .sfr_addr(sfr_addr), .xdata_write(xdata_write), .xdata_read(xdata_read),
        .xdata_addr(xdata_addr), .wdata(wdata), .rdata(rdata),
        .interrupts_enabled(interrupts_enabled), .flash_byte_written(flash_byte_written),
        .erase_started(erase_started), .select_pin(select_pin),
        .level_zero_fuse(level_zero_fuse), .level_one_fuse(level_one_fuse),
        .debug_read_req(debug_read_req), .flash_page(flash_page),
        .program_write_enable(pwe), .mass_erase_enable(mee), .code_protect_bit(cpb),
        .permanent_program_enable(ppe), .burn_level_zero(burn0), .burn_level_one(burn1),
        .external_read_block(xblk), .debug_bulk_erase_only(bulk),
        .page_zero_write_block(pz), .debug_port_disable(dpd), .debug_read_grant(grant)
    );

    // ****************************************
    // Clock, monitor, watchdog
    // ****************************************
    always #12.5 clk = ~clk;

    always @(posedge clk) begin
        rd_seen <= sfr_read | xdata_read;
    end

    // Read data stands one cycle only, so it is taken mid-cycle after the strobe
    always @(negedge clk) begin
        if (rd_seen === 1'b1 && exp_q.size() > 0) begin
            n_tests++;
            if (rdata !== exp_q[0]) begin
                fail_count++;
                $display("[ERR] %s expected %h seen %h", name_q[0], exp_q[0], rdata);
            end
            void'(exp_q.pop_front());
            void'(name_q.pop_front());
        end
    end

    initial begin
        #(25ns * 60000);
        fail_count++;
        end_of_test();
    end

    // ****************************************
    // Tasks
    // ****************************************
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic chk(input string name, input logic exp, input logic got);
        n_tests++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] %s expected %b seen %b", name, exp, got);
        end
    endtask

    task automatic access(input logic x, input logic rd, input logic [15:0] a,
                          input logic [7:0] d);
        @(posedge clk);
        if (x) begin
            xdata_addr <= a;
            xdata_write <= ~rd;
            xdata_read <= rd;
        end else begin
            sfr_addr <= a[7:0];
            sfr_write <= ~rd;
            sfr_read <= rd;
        end
        wdata <= d;
        @(posedge clk);
        {sfr_write, sfr_read, xdata_write, xdata_read} <= 4'h0;
        idle(2);
    endtask

    task automatic wr(input logic x, input logic [15:0] a, input logic [7:0] d);
        access(x, 1'b0, a, d);
    endtask

    task automatic rd(input logic x, input logic [15:0] a, input logic [7:0] e,
                      input string name);
        exp_q.push_back(e);
        name_q.push_back(name);
        access(x, 1'b1, a, 8'h00);
    endtask

    task automatic reset_dut();
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        idle(6);
    endtask

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        clk = 0; rst_n = 0; sfr_write = 0; sfr_read = 0; sfr_addr = 8'h00;
        xdata_write = 0; xdata_read = 0; xdata_addr = 16'h0000; wdata = 8'h00;
        interrupts_enabled = 0; flash_byte_written = 0; erase_started = 0;
        select_pin = 1; level_zero_fuse = 0; level_one_fuse = 0;
        debug_read_req = 1; flash_page = 8'h00; rd_seen = 0;
        fail_count = 0; n_tests = 0; seed = 32'h30d8;
        codes[0] = 8'h81; codes[1] = 8'h82;
        reset_dut();
        rd(0, 16'h00b2, 8'h00, "flash_write_control");
        rd(1, 16'hffd7, 8'h20, "protection_status_control");
        chk("debug_read_grant", 1'b1, grant);
        // Unmapped places: random offsets in both spaces, writes land nowhere
        // deliberate misuse probe
        repeat (4) begin
            v = 8'($random(seed));
            wr(1, {8'hfe, v}, 8'($random(seed)));
            rd(1, {8'hfe, v}, 8'h00, "unmapped_xdata");
            wr(0, {1'b1, v[6:0] == 7'h32 ? 7'h33 : v[6:0]}, 8'hff);
        end
        chk("pwe_after_unmapped", 1'b0, pwe);
        chk("burn_after_unmapped", 1'b0, burn0 | burn1);
        interrupts_enabled <= 1'b1;
        wr(0, 16'h00b2, 8'h01);
        chk("pwe_with_ints_on", 1'b0, pwe);
        interrupts_enabled <= 1'b0;
        wr(0, 16'h00b2, 8'h01);
        chk("pwe_set", 1'b1, pwe);
        flash_byte_written <= 1'b1;
        idle(1);
        flash_byte_written <= 1'b0;
        idle(2);
        chk("pwe_after_byte", 1'b0, pwe);
        wr(0, 16'h00b2, 8'h02);
        chk("mass_erase_set", 1'b1, mee);
        rd(0, 16'h00b2, 8'h00, "mass_erase_hidden");
        erase_started <= 1'b1;
        idle(1);
        erase_started <= 1'b0;
        idle(2);
        chk("mass_erase_used", 1'b0, mee);
        wr(1, 16'hffd7, 8'h80);
        chk("perm_enable", 1'b1, ppe);
        wr(1, 16'hffd1, 8'ha6);
        chk("burn_unarmed", 1'b0, burn0 | burn1);
        // Each selection code burns its own fuse only, then a stray value stops it
        foreach (codes[i]) begin
            wr(1, 16'hffd2, 8'h54);
            wr(1, 16'hffd2, codes[i]);
            wr(1, 16'hffd1, 8'ha6);
            chk("burn_zero", i == 0, burn0);
            chk("burn_one", i == 1, burn1);
            idle(BURN_WAIT);
            chk("burn_held", 1'b1, burn0 | burn1);
            v = 8'($random(seed));
            wr(1, 16'hffd1, v == 8'ha6 ? 8'h00 : v);
            chk("burn_stopped", 1'b0, burn0 | burn1);
            wr(1, 16'hffd2, 8'h00);
        end
        select_pin <= 1'b0;
        idle(4);
        rd(1, 16'hffd7, 8'h00, "select_pin_low");
        wr(1, 16'hffd2, 8'h54);
        wr(1, 16'hffd2, 8'h82);
        wr(1, 16'hffd1, 8'ha6);
        chk("burn_one_pin_low", 1'b0, burn1);
        wr(1, 16'hffd1, 8'h00);
        wr(1, 16'hffd2, 8'h00);
        wr(0, 16'h00b2, 8'h40);
        chk("protect_set", 1'b1, cpb);
        chk("read_block", 1'b1, xblk);
        chk("grant_blocked", 1'b0, grant);
        chk("bulk_without_fuse", 1'b0, bulk);
        wr(0, 16'h00b2, 8'h00);
        chk("protect_kept", 1'b1, cpb);
        level_zero_fuse <= 1'b1;
        idle(5);
        chk("bulk_only", 1'b1, bulk);
        chk("page_zero_block", 1'b1, pz);
        flash_page <= 8'h01;
        idle(3);
        chk("page_one_free", 1'b0, pz);
        level_one_fuse <= 1'b1;
        idle(5);
        chk("debug_disabled", 1'b1, dpd);
        level_one_fuse <= 1'b0;
        level_zero_fuse <= 1'b0;
        reset_dut();
        chk("protect_after_reset", 1'b0, cpb);
        chk("grant_after_reset", 1'b1, grant);
        chk("debug_enabled", 1'b0, dpd);
        end_of_test();
    end
endmodule
`default_nettype wire

// file: security_fuse_control.sv
// Program security, flash write enable and fuse burn sequencer
//
// Function
// - Writing 0xA6 to the burn trigger burns the selected fuse, level one only if the select pin is high at the trigger write.
// - Any other trigger value stops an ongoing burn.
// - Program-write enable redirects pointer stores from data RAM to flash.
// - Program-write enable clears itself after each flash byte write.
// - Program-write enable writes are ignored while interrupts are enabled.
// - Mass-erase enable is write-only, default off, rewritten per erase.
// - Code-protect bit clears on reset, only sets, zero writes ignored.
// - Code-protect blocks external reads of flash and coprocessor RAM.
// - Permanent-programming enable bit allows fuse programming when set.
// - Status bit 5 shows the select pin level.
// - Extra registers sit from 0xFC00; direct registers at 0x80 to 0xFF.
// - Unimplemented addresses read zero, writes to them do nothing.
// - Level-zero protection limits debug port to bulk erase, guards page zero.
// - Code-protect enables level zero only if that fuse is blown.
// - Blown level-one fuse disables debug port, sampled continuously after reset.
`default_nettype none
module security_fuse_control (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        sfr_write,
    input  wire logic        sfr_read,
    input  wire logic [7:0]  sfr_addr,
    input  wire logic        xdata_write,
    input  wire logic        xdata_read,
    input  wire logic [15:0] xdata_addr,
    input  wire logic [7:0]  wdata,
    output logic      [7:0]  rdata,
    input  wire logic        interrupts_enabled,
    input  wire logic        flash_byte_written,
    input  wire logic        erase_started,
    input  wire logic        select_pin,
    input  wire logic        level_zero_fuse,
    input  wire logic        level_one_fuse,
    input  wire logic        debug_read_req,
    input  wire logic [7:0]  flash_page,
    output logic             program_write_enable,
    output logic             mass_erase_enable,
    output logic             code_protect_bit,
    output logic             permanent_program_enable,
    output logic             burn_level_zero,
    output logic             burn_level_one,
    output logic             external_read_block,
    output logic             debug_bulk_erase_only,
    output logic             page_zero_write_block,
    output logic             debug_port_disable,
    output logic             debug_read_grant
);

    // ****************************************
    // Reset release and pin synchronisers
    // ****************************************
    logic       rst_meta;
    logic       rst_sync_n;
    logic [2:0] pin_meta;
    logic [2:0] pin_sync;
    logic [2:0] pin_raw;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta   <= 1'b0;
            rst_sync_n <= 1'b0;
        end else begin
            rst_meta   <= 1'b1;
            rst_sync_n <= rst_meta;
        end
    end

    assign pin_raw = {select_pin, level_one_fuse, level_zero_fuse};

    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            pin_meta <= 3'h0;
            pin_sync <= 3'h0;
        end else begin
            pin_meta <= pin_raw;
            pin_sync <= pin_meta;
        end
    end

    // ****************************************
    // Address decode
    // ****************************************
    // direct and extended spaces
    function automatic logic xhit(input logic [15:0] a, input logic [15:0] target);
        xhit = (a == target) && (a >= security_fuse_pkg::XDATA_SFR_BASE);
    endfunction

    logic wr_flash;
    logic wr_trigger;
    logic wr_arming;
    logic wr_status;
    logic rd_flash;
    logic rd_status;

    assign wr_flash   = sfr_write
        && (sfr_addr == security_fuse_pkg::FLASH_WRITE_CONTROL_ADDR)
        && (sfr_addr >= security_fuse_pkg::DIRECT_SFR_BASE);
    assign rd_flash   = sfr_read && (sfr_addr == security_fuse_pkg::FLASH_WRITE_CONTROL_ADDR);
    assign wr_trigger = xdata_write && xhit(xdata_addr, security_fuse_pkg::BURN_TRIGGER_ADDR);
    assign wr_arming  = xdata_write && xhit(xdata_addr, security_fuse_pkg::FUSE_ARMING_CONTROL_ADDR);
    assign wr_status  = xdata_write
        && xhit(xdata_addr, security_fuse_pkg::PROTECTION_STATUS_CONTROL_ADDR);
    assign rd_status  = xdata_read
        && xhit(xdata_addr, security_fuse_pkg::PROTECTION_STATUS_CONTROL_ADDR);

    // ****************************************
    // Flash control and security bits
    // ****************************************
    security_fuse_pkg::flash_ctrl_type ctrl;
    security_fuse_pkg::flash_ctrl_type next_ctrl;

    always_comb begin
        next_ctrl = ctrl;
        if (flash_byte_written) begin
            next_ctrl.program_write_enable = 1'b0;
        end
        if (wr_flash && !interrupts_enabled && !flash_byte_written) begin
            next_ctrl.program_write_enable = wdata[security_fuse_pkg::PROGRAM_WRITE_ENABLE_BIT];
        end
        if (erase_started) begin
            next_ctrl.mass_erase_enable = 1'b0;
        end
        if (wr_flash) begin
            next_ctrl.mass_erase_enable = wdata[security_fuse_pkg::MASS_ERASE_ENABLE_BIT];
        end
        if (wr_flash && wdata[security_fuse_pkg::CODE_PROTECT_BIT]) begin
            next_ctrl.code_protect_bit = 1'b1;
        end
        if (wr_status) begin
            next_ctrl.permanent_program_enable =
                wdata[security_fuse_pkg::PERMANENT_PROGRAM_ENABLE_BIT];
        end
    end

    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            ctrl <= '0;
        end else begin
            ctrl <= next_ctrl;
        end
    end

    // ****************************************
    // Fuse arming sequencer and burn drive
    // ****************************************
    security_fuse_pkg::arm_state_type arm_state;
    security_fuse_pkg::arm_state_type next_arm_state;
    logic                             sel_one;
    logic                             next_sel_one;
    security_fuse_pkg::burn_type      burn;
    security_fuse_pkg::burn_type      next_burn;

    always_comb begin
        next_arm_state = arm_state;
        next_sel_one   = sel_one;
        next_burn      = burn;
        if (wr_arming) begin
            case (arm_state)
                security_fuse_pkg::ARM_IDLE: begin
                    if (wdata == security_fuse_pkg::ARMING_CODE) begin
                        next_arm_state = security_fuse_pkg::ARM_ARMED;
                    end
                end
                security_fuse_pkg::ARM_ARMED,
                security_fuse_pkg::ARM_SELECTED: begin
                    if (wdata == security_fuse_pkg::SELECT_LEVEL_ZERO) begin
                        next_arm_state = security_fuse_pkg::ARM_SELECTED;
                        next_sel_one   = 1'b0;
                    end else if (wdata == security_fuse_pkg::SELECT_LEVEL_ONE) begin
                        next_arm_state = security_fuse_pkg::ARM_SELECTED;
                        next_sel_one   = 1'b1;
                    end else if (wdata != security_fuse_pkg::ARMING_CODE) begin
                        next_arm_state = security_fuse_pkg::ARM_IDLE;
                    end
                end
                default: begin
                    next_arm_state = security_fuse_pkg::ARM_IDLE;
                end
            endcase
        end
        if (wr_trigger) begin
            if (wdata == security_fuse_pkg::TRIGGER_CODE
                && arm_state == security_fuse_pkg::ARM_SELECTED
                && ctrl.permanent_program_enable) begin
                next_burn.burn_level_zero = !sel_one;
                next_burn.burn_level_one  = sel_one && pin_sync[2];
            end else begin
                next_burn = '0;
            end
        end
        // Dropping arming also ends the pulse so a stale burn cannot linger
        if (next_arm_state == security_fuse_pkg::ARM_IDLE) begin
            next_burn = '0;
        end
    end

    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            arm_state <= security_fuse_pkg::ARM_IDLE;
            sel_one   <= 1'b0;
            burn      <= '0;
        end else begin
            arm_state <= next_arm_state;
            sel_one   <= next_sel_one;
            burn      <= next_burn;
        end
    end

    // ****************************************
    // Protection outputs and read data
    // ****************************************
    logic [7:0] next_rdata;
    logic       next_debug_grant;
    logic       level_zero_active;

    assign level_zero_active = next_ctrl.code_protect_bit && pin_sync[0];

    always_comb begin
        next_rdata = 8'h00;
        if (rd_flash) begin
            next_rdata[security_fuse_pkg::PROGRAM_WRITE_ENABLE_BIT] = ctrl.program_write_enable;
            next_rdata[security_fuse_pkg::CODE_PROTECT_BIT]         = ctrl.code_protect_bit;
        end else if (rd_status) begin
            next_rdata[security_fuse_pkg::SELECT_PIN_LEVEL_BIT] = pin_sync[2];
            next_rdata[security_fuse_pkg::LEVEL_ONE_FUSE_BIT]   = pin_sync[1];
            next_rdata[security_fuse_pkg::LEVEL_ZERO_FUSE_BIT]  = pin_sync[0];
        end
        next_debug_grant = debug_read_req && !next_ctrl.code_protect_bit && !pin_sync[1];
    end

    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            rdata                    <= 8'h00;
            program_write_enable     <= 1'b0;
            mass_erase_enable        <= 1'b0;
            code_protect_bit         <= 1'b0;
            permanent_program_enable <= 1'b0;
            burn_level_zero          <= 1'b0;
            burn_level_one           <= 1'b0;
            external_read_block      <= 1'b0;
            debug_bulk_erase_only    <= 1'b0;
            page_zero_write_block    <= 1'b0;
            debug_port_disable       <= 1'b0;
            debug_read_grant         <= 1'b0;
        end else begin
            rdata                    <= next_rdata;
            program_write_enable     <= next_ctrl.program_write_enable;
            mass_erase_enable        <= next_ctrl.mass_erase_enable;
            code_protect_bit         <= next_ctrl.code_protect_bit;
            permanent_program_enable <= next_ctrl.permanent_program_enable;
            burn_level_zero          <= next_burn.burn_level_zero;
            burn_level_one           <= next_burn.burn_level_one;
            external_read_block      <= next_ctrl.code_protect_bit;
            debug_bulk_erase_only    <= level_zero_active;
            page_zero_write_block    <= level_zero_active && (flash_page == 8'h00);
            debug_port_disable       <= pin_sync[1];
            debug_read_grant         <= next_debug_grant;
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_sync_n);

    protect_sticky_a: assert property (code_protect_bit |=> code_protect_bit)
        else $error("code protect bit cleared");
    pwe_selfclear_a: assert property (flash_byte_written |=> !program_write_enable)
        else $error("program write enable not cleared");
    pwe_irq_lock_a: assert property (
        (interrupts_enabled && !flash_byte_written) |=> $stable(program_write_enable))
        else $error("program write enable changed with interrupts on");
    burn_start_a: assert property (
        (wr_trigger && wdata == security_fuse_pkg::TRIGGER_CODE
         && arm_state == security_fuse_pkg::ARM_SELECTED && !sel_one
         && ctrl.permanent_program_enable && !wr_arming) |=> burn_level_zero)
        else $error("burn did not start");
    burn_stop_a: assert property (
        (wr_trigger && wdata != security_fuse_pkg::TRIGGER_CODE)
        |=> !burn_level_zero && !burn_level_one)
        else $error("burn not stopped");
    burn_guard_a: assert property (
        (arm_state != security_fuse_pkg::ARM_SELECTED && !burn_level_zero && !burn_level_one)
        |=> !burn_level_zero && !burn_level_one)
        else $error("burn without arming");
    one_fuse_a: assert property (!(burn_level_zero && burn_level_one))
        else $error("both fuses burning");
    level_one_pin_a: assert property (burn_level_one |-> $past(pin_sync[2]))
        else $error("level one burn with pin low");
    read_block_a: assert property (code_protect_bit |-> !debug_read_grant)
        else $error("read granted while protected");
    debug_off_a: assert property (pin_sync[1] |=> debug_port_disable)
        else $error("debug port not disabled");

    burn_zero_c: cover property (burn_level_zero);
    burn_one_c: cover property (burn_level_one);
    protect_c: cover property (code_protect_bit && debug_bulk_erase_only);
    pwe_clear_c: cover property (program_write_enable ##1 !program_write_enable);

endmodule
`default_nettype wire

// file: security_fuse_pkg.sv
// Package: register map, field positions and codes for the program security block
`default_nettype none
package security_fuse_pkg;

    // ****************************************
    // Register addresses
    // ****************************************
    localparam logic [7:0]  FLASH_WRITE_CONTROL_ADDR       = 8'hb2;
    localparam logic [15:0] BURN_TRIGGER_ADDR              = 16'hffd1;
    localparam logic [15:0] FUSE_ARMING_CONTROL_ADDR       = 16'hffd2;
    localparam logic [15:0] PROTECTION_STATUS_CONTROL_ADDR = 16'hffd7;
    localparam logic [15:0] XDATA_SFR_BASE                 = 16'hfc00;
    localparam logic [7:0]  DIRECT_SFR_BASE                = 8'h80;

    // ****************************************
    // Field positions
    // ****************************************
    localparam int PROGRAM_WRITE_ENABLE_BIT    = 0;
    localparam int MASS_ERASE_ENABLE_BIT       = 1;
    localparam int CODE_PROTECT_BIT            = 6;
    localparam int PERMANENT_PROGRAM_ENABLE_BIT = 7;
    localparam int SELECT_PIN_LEVEL_BIT        = 5;
    localparam int LEVEL_ONE_FUSE_BIT          = 1;
    localparam int LEVEL_ZERO_FUSE_BIT         = 0;

    // ****************************************
    // Codes and reset values
    // ****************************************
    localparam logic [7:0] ARMING_CODE       = 8'h54;
    localparam logic [7:0] SELECT_LEVEL_ZERO = 8'h81;
    localparam logic [7:0] SELECT_LEVEL_ONE  = 8'h82;
    localparam logic [7:0] TRIGGER_CODE      = 8'ha6;
    localparam logic [7:0] REG_RESET         = 8'h00;

    // ****************************************
    // Carriers
    // ****************************************
    typedef enum logic [1:0] {
        ARM_IDLE,
        ARM_ARMED,
        ARM_SELECTED
    } arm_state_type;

    typedef struct packed {
        logic program_write_enable;
        logic mass_erase_enable;
        logic code_protect_bit;
        logic permanent_program_enable;
    } flash_ctrl_type;

    typedef struct packed {
        logic burn_level_zero;
        logic burn_level_one;
    } burn_type;

endpackage
`default_nettype wire
